// ---- spw_consts.svh ----
`ifndef SPW_CONSTS_SVH
`define SPW_CONSTS_SVH

// register byte addresses
`define SPW_OFF_DATA    12'h300
`define SPW_OFF_CTRL    12'h304
`define SPW_OFF_STAT    12'h308
`define SPW_OFF_GAP     12'h30C
`define SPW_OFF_PIN     12'h310

// serial_main_control fields
`define SPW_CTL_MASTER  0
`define SPW_CTL_W16     1
`define SPW_CTL_GPIO    2
`define SPW_CTL_TEST1   3
`define SPW_CTL_CNT     14:8
`define SPW_CTL_CONT    15
`define SPW_CTL_XFER    31
`define SPW_CTL_MASK    32'h8000FF0F
`define SPW_CTL_RESET   32'h00000000

// fifo_free_count_status fields
`define SPW_STAT_BUSY   0
`define SPW_STAT_TX     15:9
`define SPW_STAT_RX     22:16

// inter_word_gap_count
`define SPW_GAP_MASK    32'h0000FFFF
`define SPW_GAP_RESET   32'h00000000

// serial_pin_io_control fields
`define SPW_PIN_MASK    32'h0000FFFF
`define SPW_PIN_RESET   32'h00000000
`define SPW_PIN_SCK     0
`define SPW_PIN_MOSI    1
`define SPW_PIN_MISO    2
`define SPW_PIN_SS      3
`define SPW_PIN_SS_OE   4
`define SPW_PIN_SS_IE   5
`define SPW_PIN_SCK_OE  6
`define SPW_PIN_SCK_IE  7
`define SPW_PIN_MOSI_OE 8
`define SPW_PIN_MOSI_IE 9
`define SPW_PIN_MISO_OE 10
`define SPW_PIN_MISO_IE 11
`define SPW_PIN_PU_SS   12
`define SPW_PIN_PU_SCK  13
`define SPW_PIN_PU_MOSI 14
`define SPW_PIN_PU_MISO 15

// fifo depths and word sizes
`define SPW_DEPTH8      7'h40
`define SPW_DEPTH16     7'h20
`define SPW_BITS8       5'h08
`define SPW_BITS16      5'h10

// timing
`define SPW_CLK_HZ      50000000
`define SPW_SCK_HZ      1000000
`define SPW_SCK_HALF    ((`SPW_CLK_HZ) / (2 * (`SPW_SCK_HZ)))
`define SPW_SCK_PER     (2 * (`SPW_SCK_HALF))
`define SPW_TST8_BIT    7
`define SPW_TST20_BIT   19

// bus responses
`define SPW_RESP_OK     2'h0
`define SPW_RESP_ERR    2'h2

`endif

// ---- spw_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module spw_fifo (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // queue
  spw_fifo_if.store f
);
  logic [15:0] mem [64];
  logic [5:0]  wp;
  logic [5:0]  rp;
  logic [6:0]  cnt;
  wire         do_push = f.push & ~f.full;
  wire         do_pop  = f.pop & ~f.empty;

  assign f.rdata = mem[rp];
  assign f.count = cnt;
  assign f.full  = (cnt >= f.cap);
  assign f.empty = (cnt == 7'h00);

  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[wp] <= f.wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || f.flush) begin
      wp  <= 6'h00;
      rp  <= 6'h00;
      cnt <= 7'h00;
    end else begin
      if (do_push) begin
        wp <= wp + 6'h01;
      end
      if (do_pop) begin
        rp <= rp + 6'h01;
      end
      if (do_push && !do_pop) begin
        cnt <= cnt + 7'h01;
      end else if (do_pop && !do_push) begin
        cnt <= cnt - 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- spw_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface spw_fifo_if;
  logic        push;
  logic        pop;
  logic        flush;
  logic [15:0] wdata;
  logic [6:0]  cap;
  logic [15:0] rdata;
  logic [6:0]  count;
  logic        full;
  logic        empty;
  modport store (input push, pop, flush, wdata, cap,
                 output rdata, count, full, empty);
  modport user  (output push, pop, flush, wdata, cap,
                 input rdata, count, full, empty);
endinterface
`default_nettype wire

// ---- spw_gap.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spw_consts.svh"
module spw_gap (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // control
  input  wire logic        start,
  input  wire logic [15:0] gap_len,
  // result
  output logic             done,
  output logic [15:0]      count
);
  logic [7:0] cyc;
  logic       run;

  // done lands one cycle after gap_len whole periods: strictly longer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run   <= 1'b0;
      cyc   <= 8'h00;
      count <= 16'h0000;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        run   <= 1'b1;
        cyc   <= 8'h00;
        count <= 16'h0000;
      end else if (run) begin
        if (count == gap_len) begin
          run  <= 1'b0;
          done <= 1'b1;
        end else if (cyc == 8'(`SPW_SCK_PER - 1)) begin
          cyc   <= 8'h00;
          count <= count + 16'h0001;
        end else begin
          cyc <= cyc + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- spw_pkg.sv ----
package spw_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_GAP   = 3'b100
  } spw_state_t;
endpackage

// ---- spw_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spw_slave_model (
  // pads
  input  wire logic   aclk,
  input  wire logic   ss,
  input  wire logic   sck,
  input  wire logic   mosi,
  output logic        miso,
  // observed traffic
  output logic [15:0] got,
  output int          gap
);
  logic [15:0] sh = 16'hC33C;
  logic        ss_q = 1'b1;
  logic        sck_q = 1'b0;
  int          cnt = 0;
  // not selected: show the inverse so a stale bit never passes
  assign miso = ss ? !sh[15] : sh[15];
  always @(posedge aclk) begin
    ss_q <= ss;
    sck_q <= sck;
    if (ss)
      cnt <= cnt + 1;
    if (ss_q && !ss) begin
      sh <= 16'hC33C;
      gap <= cnt;
      cnt <= 0;
    end else if (!ss && sck_q && !sck)
      sh <= {sh[14:0], 1'b0};
    if (!ss && !sck_q && sck)
      got <= {got[14:0], mosi};
  end
endmodule
`default_nettype wire

// ---- spw_top.sv ----
// Behaviour
// (R1) transmit free count is read-only in status bits 15:9; depth 64 or 32
// (R2) transmit free reads 0 when full, 64 or 32 when empty
// (R3) receive free count is read-only in status bits 22:16; 31:23 zero
// (R4) receive free reads 0 when full, 32 or 64 when empty
// (R5) 8-bit words sit in data bits 7:0, bit 7 most significant
// (R6) 16-bit words use bits 15:8 high and 7:0 low, bit 15 MSB
// (R7) data read pops receive queue, write pushes transmit; bits 31:16 zero
// (R8) master leaves gap longer than serial period times gap register
// (R9) gap applies to write-started and enable-bit-started transfers
// (R10) pin bits 2:0 are clock, master-out, master-in data in pin mode
// (R11) test mode: bit 1 gap counter, bit 2 8-bit divider; read zero
// (R12) bit 3 is select pin data; test mode drives 20-bit divider
// (R13) 2-bit fields at 5:4..11:10 enable output and input per pin
// (R14) bits 15:12 are pull-up controls, 0 active, 1 inactive
// (R15) pull-ups active during reset, register-controlled afterwards
// (R16) enable bit 31 starts transfers without writes, still sends queue
// (R17) free counts follow every push and pop in the same cycle
// (R18) host checks free counts before reading or writing data port
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "spw_consts.svh"
module spw_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // select pin, shared with indicator_output
  input  wire logic        select_shared_pin_i,
  output logic             select_shared_pin_o,
  output logic             select_shared_pin_oe,
  // clock pin
  input  wire logic        clock_shared_pin_i,
  output logic             clock_shared_pin_o,
  output logic             clock_shared_pin_oe,
  // master-out pin
  input  wire logic        mosi_shared_pin_i,
  output logic             mosi_shared_pin_o,
  output logic             mosi_shared_pin_oe,
  // master-in pin
  input  wire logic        miso_shared_pin_i,
  output logic             miso_shared_pin_o,
  output logic             miso_shared_pin_oe,
  // pull-up enables, high turns the pull-up on
  output logic             select_pin_pullup,
  output logic             clock_pin_pullup,
  output logic             mosi_pin_pullup,
  output logic             miso_pin_pullup
);
  logic [31:0] serial_main_control;
  logic [31:0] inter_word_gap_count;
  logic [31:0] serial_pin_io_control;

  spw_fifo_if tx_f ();
  spw_fifo_if rx_f ();

  spw_fifo u_tx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .f       (tx_f)
  );

  spw_fifo u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .f       (rx_f)
  );

  // ---------------- bus slave ----------------
  logic        aw_got;
  logic        w_got;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire aw_take  = awvalid & awready;
  wire w_take   = wvalid & wready;
  wire do_write = aw_got & w_got & ~bvalid;
  wire b_done   = bvalid & bready;
  wire ar_take  = arvalid & arready;
  wire r_done   = rvalid & rready;

  wire next_aw_got = aw_take | (aw_got & ~do_write);
  wire next_w_got  = w_take | (w_got & ~do_write);
  wire next_bvalid = do_write | (bvalid & ~b_done);
  wire next_rvalid = ar_take | (rvalid & ~r_done);

  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                       {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wr_merge_ctrl = (serial_main_control & ~wmask)
                              | (w_data & wmask);
  wire [31:0] ctrl_wval = wr_merge_ctrl & `SPW_CTL_MASK;

  wire wa_data = (aw_addr == `SPW_OFF_DATA);
  wire wa_ctrl = (aw_addr == `SPW_OFF_CTRL);
  wire wa_stat = (aw_addr == `SPW_OFF_STAT);
  wire wa_gap  = (aw_addr == `SPW_OFF_GAP);
  wire wa_pin  = (aw_addr == `SPW_OFF_PIN);
  wire wa_ok   = wa_data | wa_ctrl | wa_stat | wa_gap | wa_pin;

  wire wr_data = do_write & wa_data & (|w_strb[1:0]);
  wire wr_ctrl = do_write & wa_ctrl;
  wire wr_gap  = do_write & wa_gap;
  wire wr_pin  = do_write & wa_pin;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `SPW_RESP_OK;
    end else begin
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      bvalid  <= next_bvalid;
      awready <= ~next_aw_got & ~next_bvalid;
      wready  <= ~next_w_got & ~next_bvalid;
      if (aw_take) begin
        aw_addr <= awaddr;
      end
      if (w_take) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        bresp <= wa_ok ? `SPW_RESP_OK : `SPW_RESP_ERR;
      end
    end
  end

  // ---------------- free counts ----------------
  wire       w16     = serial_main_control[`SPW_CTL_W16];
  wire [6:0] cap     = w16 ? `SPW_DEPTH16 : `SPW_DEPTH8;
  wire [6:0] tx_free = cap - tx_f.count; // R1 R2 R17
  wire [6:0] rx_free = cap - rx_f.count; // R3 R4 R17

  // ---------------- read path ----------------
  spw_pkg::spw_state_t state;
  logic [15:0] gap_cnt;
  logic [19:0] tst_cnt;

  wire gpio  = serial_main_control[`SPW_CTL_GPIO];
  wire test1 = serial_main_control[`SPW_CTL_TEST1];
  wire busy  = (state != spw_pkg::ST_IDLE);

  // in pin mode, pin data reads the pad when its input is enabled; test bits read zero
  wire rd_sck  = (gpio & serial_pin_io_control[`SPW_PIN_SCK_IE])
                 ? clock_shared_pin_i
                 : serial_pin_io_control[`SPW_PIN_SCK]; // R10
  wire rd_mosi = test1 ? 1'b0
                 : (gpio & serial_pin_io_control[`SPW_PIN_MOSI_IE])
                 ? mosi_shared_pin_i
                 : serial_pin_io_control[`SPW_PIN_MOSI]; // R10 R11
  wire rd_miso = test1 ? 1'b0
                 : (gpio & serial_pin_io_control[`SPW_PIN_MISO_IE])
                 ? miso_shared_pin_i
                 : serial_pin_io_control[`SPW_PIN_MISO]; // R10 R11
  wire rd_ss   = test1 ? 1'b0
                 : (gpio & serial_pin_io_control[`SPW_PIN_SS_IE])
                 ? select_shared_pin_i
                 : serial_pin_io_control[`SPW_PIN_SS]; // R12

  wire [31:0] stat_val = {9'h000, rx_free, tx_free, 8'h00, busy}; // R1 R3
  wire [31:0] pin_val  = {16'h0000, serial_pin_io_control[15:4],
                          rd_ss, rd_miso, rd_mosi, rd_sck};
  // empty receive queue reads zero rather than stale storage
  wire [31:0] data_val = rx_f.empty ? 32'h00000000
                         : {16'h0000, rx_f.rdata}; // R7

  wire ra_data = (araddr == `SPW_OFF_DATA);
  wire ra_ctrl = (araddr == `SPW_OFF_CTRL);
  wire ra_stat = (araddr == `SPW_OFF_STAT);
  wire ra_gap  = (araddr == `SPW_OFF_GAP);
  wire ra_pin  = (araddr == `SPW_OFF_PIN);
  wire ra_ok   = ra_data | ra_ctrl | ra_stat | ra_gap | ra_pin;

  wire [31:0] rd_val = ra_data ? data_val
                     : ra_ctrl ? serial_main_control
                     : ra_stat ? stat_val
                     : ra_gap  ? inter_word_gap_count
                     : ra_pin  ? pin_val
                     : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid  <= 1'b0;
      arready <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `SPW_RESP_OK;
    end else begin
      rvalid  <= next_rvalid;
      arready <= ~next_rvalid;
      if (ar_take) begin
        rdata <= rd_val;
        rresp <= ra_ok ? `SPW_RESP_OK : `SPW_RESP_ERR;
      end
    end
  end

  // ---------------- serial engine ----------------
  logic        sck;
  logic [7:0]  half_cnt;
  logic [15:0] sh_tx;
  logic [15:0] sh_rx;
  logic [4:0]  bit_cnt;
  logic [6:0]  words_left;
  logic        gap_done;

  wire       master   = serial_main_control[`SPW_CTL_MASTER];
  wire       xfer     = serial_main_control[`SPW_CTL_XFER];
  wire       cont     = serial_main_control[`SPW_CTL_CONT];
  wire       can_run  = master & ~gpio;
  wire [4:0] nbits    = w16 ? `SPW_BITS16 : `SPW_BITS8;
  wire       half_tick = (half_cnt == 8'(`SPW_SCK_HALF - 1));
  wire       xfer_go  = xfer & (cont | (words_left != 7'h00)); // R16
  wire       xfer_end = xfer & ~cont & (words_left == 7'h00);
  wire       in_idle  = (state == spw_pkg::ST_IDLE);
  wire       start_word = in_idle & can_run & (~tx_f.empty | xfer_go);
  wire       last_fall  = (state == spw_pkg::ST_SHIFT) & half_tick & sck
                          & (bit_cnt == nbits - 5'h01);
  wire       hw_clr_xfer = (start_word & xfer & ~cont
                            & (words_left == 7'h01))
                           | (in_idle & can_run & xfer_end);
  // 8-bit words leave from bit 7, so lift them to the shifter top
  wire [15:0] tx_word = tx_f.empty ? 16'h0000
                        : w16 ? tx_f.rdata
                        : {tx_f.rdata[7:0], 8'h00}; // R5 R6 R16

  assign tx_f.push  = wr_data; // R7
  assign tx_f.wdata = w16 ? w_data[15:0]
                      : {8'h00, w_data[7:0]}; // R5 R6
  assign tx_f.pop   = start_word & ~tx_f.empty; // R16
  assign tx_f.cap   = cap;
  // changing word width would reinterpret stored words, so both flush
  assign tx_f.flush = wr_ctrl & (ctrl_wval[`SPW_CTL_W16] != w16);
  assign rx_f.push  = last_fall;
  assign rx_f.wdata = w16 ? sh_rx : {8'h00, sh_rx[7:0]}; // R5 R6
  assign rx_f.pop   = ar_take & ra_data & ~rx_f.empty; // R7 R18
  assign rx_f.cap   = cap;
  assign rx_f.flush = tx_f.flush;

  spw_gap u_gap (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (last_fall),
    .gap_len (inter_word_gap_count[15:0]),
    .done    (gap_done),
    .count   (gap_cnt)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_main_control   <= `SPW_CTL_RESET;
      inter_word_gap_count  <= `SPW_GAP_RESET;
      serial_pin_io_control <= `SPW_PIN_RESET;
      words_left            <= 7'h00;
    end else begin
      // software write of the enable bit wins over the hardware clear
      if (wr_ctrl) begin
        serial_main_control <= ctrl_wval;
        words_left          <= ctrl_wval[`SPW_CTL_CNT];
      end else begin
        if (hw_clr_xfer) begin
          serial_main_control[`SPW_CTL_XFER] <= 1'b0;
        end
        if (start_word & xfer & ~cont) begin
          words_left <= words_left - 7'h01;
        end
      end
      if (wr_gap) begin
        inter_word_gap_count <= ((inter_word_gap_count & ~wmask)
                                 | (w_data & wmask)) & `SPW_GAP_MASK;
      end
      if (wr_pin) begin
        serial_pin_io_control <= ((serial_pin_io_control & ~wmask)
                                  | (w_data & wmask)) & `SPW_PIN_MASK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= spw_pkg::ST_IDLE;
      sck      <= 1'b0;
      half_cnt <= 8'h00;
      sh_tx    <= 16'h0000;
      sh_rx    <= 16'h0000;
      bit_cnt  <= 5'h00;
      tst_cnt  <= 20'h00000;
    end else begin
      tst_cnt <= tst_cnt + 20'h00001;
      unique case (state)
        spw_pkg::ST_IDLE: begin
          if (start_word) begin // R9 R16
            state    <= spw_pkg::ST_SHIFT;
            sh_tx    <= tx_word;
            bit_cnt  <= 5'h00;
            half_cnt <= 8'h00;
            sck      <= 1'b0;
          end
        end
        spw_pkg::ST_SHIFT: begin
          half_cnt <= half_tick ? 8'h00 : half_cnt + 8'h01;
          if (half_tick) begin
            sck <= ~sck;
            if (!sck) begin
              sh_rx <= {sh_rx[14:0], miso_shared_pin_i};
            end else begin
              sh_tx   <= {sh_tx[14:0], 1'b0};
              bit_cnt <= bit_cnt + 5'h01;
              if (last_fall) begin
                state <= spw_pkg::ST_GAP; // R8 R9
              end
            end
          end
        end
        spw_pkg::ST_GAP: begin
          if (gap_done) begin // R8
            state <= spw_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- pads ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_shared_pin_o  <= 1'b0;
      select_shared_pin_oe <= 1'b0;
      clock_shared_pin_o   <= 1'b0;
      clock_shared_pin_oe  <= 1'b0;
      mosi_shared_pin_o    <= 1'b0;
      mosi_shared_pin_oe   <= 1'b0;
      miso_shared_pin_o    <= 1'b0;
      miso_shared_pin_oe   <= 1'b0;
      select_pin_pullup    <= 1'b1; // R15
      clock_pin_pullup     <= 1'b1; // R15
      mosi_pin_pullup      <= 1'b1; // R15
      miso_pin_pullup      <= 1'b1; // R15
    end else begin
      select_pin_pullup <= ~serial_pin_io_control[`SPW_PIN_PU_SS]; // R14
      clock_pin_pullup  <= ~serial_pin_io_control[`SPW_PIN_PU_SCK]; // R14
      mosi_pin_pullup   <= ~serial_pin_io_control[`SPW_PIN_PU_MOSI]; // R14
      miso_pin_pullup   <= ~serial_pin_io_control[`SPW_PIN_PU_MISO]; // R14
      if (gpio) begin
        select_shared_pin_oe <= serial_pin_io_control[`SPW_PIN_SS_OE]; // R13
        clock_shared_pin_oe  <= serial_pin_io_control[`SPW_PIN_SCK_OE]; // R13
        mosi_shared_pin_oe   <= serial_pin_io_control[`SPW_PIN_MOSI_OE]; // R13
        miso_shared_pin_oe   <= serial_pin_io_control[`SPW_PIN_MISO_OE]; // R13
        clock_shared_pin_o   <= serial_pin_io_control[`SPW_PIN_SCK]; // R10
        if (test1) begin
          mosi_shared_pin_o   <= gap_cnt[0]; // R11
          miso_shared_pin_o   <= tst_cnt[`SPW_TST8_BIT]; // R11
          select_shared_pin_o <= tst_cnt[`SPW_TST20_BIT]; // R12
        end else begin
          mosi_shared_pin_o   <= serial_pin_io_control[`SPW_PIN_MOSI]; // R10
          miso_shared_pin_o   <= serial_pin_io_control[`SPW_PIN_MISO]; // R10
          select_shared_pin_o <= serial_pin_io_control[`SPW_PIN_SS]; // R12
        end
      end else if (master) begin
        // select is low only while bits move, high across the gap
        select_shared_pin_o  <= (state != spw_pkg::ST_SHIFT);
        select_shared_pin_oe <= 1'b1;
        clock_shared_pin_o   <= sck;
        clock_shared_pin_oe  <= 1'b1;
        mosi_shared_pin_o    <= sh_tx[15]; // R5 R6
        mosi_shared_pin_oe   <= 1'b1;
        miso_shared_pin_o    <= 1'b0;
        miso_shared_pin_oe   <= 1'b0;
      end else begin
        // slave operation is outside this block: pads float
        select_shared_pin_o  <= 1'b0;
        select_shared_pin_oe <= 1'b0;
        clock_shared_pin_o   <= 1'b0;
        clock_shared_pin_oe  <= 1'b0;
        mosi_shared_pin_o    <= 1'b0;
        mosi_shared_pin_oe   <= 1'b0;
        miso_shared_pin_o    <= 1'b0;
        miso_shared_pin_oe   <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- spw_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spw_consts.svh"
module spw_top_bench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  wire  [3:0]  po, poe, pu;
  logic [1:0]  bresp, rresp, rr;
  logic [15:0] got;
  wire         miso;
  // undriven pads sit high on their pull-ups
  wire  [3:0]  pw = (po & poe) | ~poe;
  int          gap, err_count, checks, cyc;
  spw_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .select_shared_pin_i(pw[0]),
    .select_shared_pin_o(po[0]), .select_shared_pin_oe(poe[0]),
    .clock_shared_pin_i(pw[1]), .clock_shared_pin_o(po[1]),
    .clock_shared_pin_oe(poe[1]), .mosi_shared_pin_i(pw[2]),
    .mosi_shared_pin_o(po[2]), .mosi_shared_pin_oe(poe[2]),
    .miso_shared_pin_i(poe[3] ? po[3] : miso), .miso_shared_pin_o(po[3]),
    .miso_shared_pin_oe(poe[3]), .select_pin_pullup(pu[0]),
    .clock_pin_pullup(pu[1]), .mosi_pin_pullup(pu[2]),
    .miso_pin_pullup(pu[3]));
  spw_slave_model peer (.aclk, .ss(pw[0]), .sck(pw[1]), .mosi(pw[2]),
    .miso, .got, .gap);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      test_done();
    end
  end
  task test_done;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic ab, wb;
    ab = 1'b1;
    wb = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (ab || wb) begin
      @(posedge aclk);
      if (ab && awready) begin
        ab = 1'b0;
        awvalid <= 1'b0;
      end
      if (wb && wready) begin
        wb = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    rr = rresp;
  endtask
  task st(input logic [6:0] tx, input logic [6:0] rx);
    rd(`SPW_OFF_STAT, v);
    chk({18'h0, v[22:9]}, {18'h0, rx, tx});
  endtask
  task wrx(input logic [6:0] rx);
    int n;
    n = 0;
    do begin
      rd(`SPW_OFF_STAT, v);
      n++;
    end while (v[22:16] !== rx && n < 3000);
    chk({25'h0, v[22:16]}, {25'h0, rx});
  endtask
  task t_regs;
    st(`SPW_DEPTH8, `SPW_DEPTH8);
    chk({28'h0, pu}, 32'hF);
    wr(`SPW_OFF_GAP, 32'hFFFFFFFF);
    rd(`SPW_OFF_GAP, v);
    chk(v, 32'h0000FFFF);
    wr(`SPW_OFF_PIN, 32'h00005000);
    repeat (2) @(posedge aclk);
    chk({28'h0, pu}, 32'hA);
    wr(`SPW_OFF_PIN, 32'h0);
    rd(12'h314, v);
    chk({30'h0, rr}, {30'h0, `SPW_RESP_ERR});
  endtask
  task t_pins;
    wr(`SPW_OFF_CTRL, 32'h4);
    for (int e = 0; e < 4; e++) begin
      wr(`SPW_OFF_PIN, {20'h0, {4{e[1:0]}}, 4'hA});
      repeat (2) @(posedge aclk);
      chk({28'h0, poe}, {28'h0, {4{e[0]}}});
      if (e[0])
        chk({28'h0, po}, 32'h5);
    end
    rd(`SPW_OFF_PIN, v);
    chk(v, 32'h00000FFA);
    wr(`SPW_OFF_CTRL, 32'hC);
    rd(`SPW_OFF_PIN, v);
    chk(v, 32'h00000FF0);
  endtask
  task t_fill(input logic [31:0] c, input logic [6:0] d);
    wr(`SPW_OFF_CTRL, c);
    for (int i = 0; i < d; i++) begin
      st(d - i[6:0], d);
      wr(`SPW_OFF_DATA, i);
    end
    wr(`SPW_OFF_DATA, 32'h0);
    st(7'h0, d);
  endtask
  task t_link;
    wr(`SPW_OFF_GAP, 32'h2);
    wr(`SPW_OFF_CTRL, 32'h1);
    wr(`SPW_OFF_DATA, 32'hA5);
    wr(`SPW_OFF_DATA, 32'h5A);
    wrx(7'h3E);
    chk({16'h0, got}, 32'hA55A);
    chk(gap > 2 * `SPW_SCK_PER, 1);
    rd(`SPW_OFF_DATA, v);
    chk(v, 32'hC3);
    rd(`SPW_OFF_DATA, v);
    chk(v, 32'hC3);
    wr(`SPW_OFF_CTRL, 32'h3);
    wr(`SPW_OFF_DATA, 32'h1234);
    wrx(`SPW_DEPTH16 - 7'h1);
    chk({16'h0, got}, 32'h1234);
    rd(`SPW_OFF_DATA, v);
    chk(v, 32'hC33C);
  endtask
  task t_en;
    wr(`SPW_OFF_CTRL, 32'h80000201);
    wrx(7'h3E);
    chk({16'h0, got}, 32'h0);
    rd(`SPW_OFF_DATA, v);
    chk(v, 32'hC3);
    rd(`SPW_OFF_CTRL, v);
    chk(v & 32'h80000000, 32'h0);
  endtask
  initial begin
    {aresetn, awvalid, wvalid, arvalid} = 4'h0;
    {bready, rready} = 2'h3;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hF;
    {err_count, checks, cyc} = 96'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_pins;
    t_fill(32'h0, `SPW_DEPTH8);
    t_fill(32'h2, `SPW_DEPTH16);
    t_link;
    t_en;
    test_done;
  end
endmodule
`default_nettype wire

// ---- spw_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "spw_consts.svh"
module spw_top_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [11:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // pull-ups
  input wire logic        select_pin_pullup,
  input wire logic        clock_pin_pullup,
  input wire logic        mosi_pin_pullup,
  input wire logic        miso_pin_pullup
);
  logic [11:0] ra;
  wire         pu_all = select_pin_pullup & clock_pin_pullup
                      & mosi_pin_pullup & miso_pin_pullup;
  wire         unm = ra < 12'h300 || ra > 12'h310 || ra[1:0] != 2'h0;
  wire         st_rd = rvalid && ra == `SPW_OFF_STAT;
  always_ff @(posedge aclk) begin
    if (arvalid && arready)
      ra <= araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wtake;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rtake;
    arvalid && arready;
  endsequence
  AST_PU_RST: assert property ($rose(aresetn) |-> pu_all)
    else $error("pull-ups not active out of reset");
  AST_W_SEQ: assert property (s_wtake |=> !awready && !wready ##1 bvalid)
    else $error("write answer out of order");
  AST_B_DONE: assert property (bvalid && bready |=> !bvalid)
    else $error("write response not released");
  AST_RD_LAT: assert property (s_rtake |=> rvalid)
    else $error("read answer late");
  AST_R_DONE: assert property (rvalid && rready |=> !rvalid)
    else $error("read data not released");
  AST_STAT_RSV: assert property (st_rd |-> rdata[31:23] == 9'h0)
    else $error("status top bits set");
  AST_FREE_MAX: assert property (st_rd |-> rdata[15:9] <= 7'h40
    && rdata[22:16] <= 7'h40) else $error("free count above depth");
  AST_DATA_RSV: assert property (rvalid && ra == `SPW_OFF_DATA
    |-> rdata[31:16] == 16'h0) else $error("data top bits set");
  AST_UNMAP: assert property (rvalid && unm |-> rresp == `SPW_RESP_ERR
    && rdata == 32'h0) else $error("unmapped read not refused");
endmodule
bind spw_top spw_top_sva u_sva (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .select_pin_pullup, .clock_pin_pullup, .mosi_pin_pullup,
  .miso_pin_pullup);
`default_nettype wire
